// ===== rtl/sfwp_consts.svh
// Constants of the serial flash write-protection block
`ifndef SFWP_CONSTS_SVH
`define SFWP_CONSTS_SVH
`define SFWP_CMD_SET_WRITE_ENABLE_CMD 8'h06
`define SFWP_CMD_WRDI 8'h04
`define SFWP_CMD_SE 8'h20
`define SFWP_CMD_BE 8'hD8
`define SFWP_CMD_BE32 8'h52
`define SFWP_CMD_CE1 8'h60
`define SFWP_CMD_CE2 8'hC7
`define SFWP_CMD_PP 8'h02
`define SFWP_CMD_PP4 8'h38
`define SFWP_CMD_WRSR 8'h01
`define SFWP_CMD_DP 8'hB9
`define SFWP_CMD_WAKE 8'hAB
`define SFWP_CMD_RSIG 8'hAB
`define SFWP_CMD_ENTER_OTP_CMD 8'hB1
`define SFWP_CMD_EXIT_OTP_CMD 8'hC1
`define SFWP_CMD_WRITE_SECURITY_CMD 8'h2F
`define SFWP_OTP_LAST 12'h1FF
`define SFWP_BLK_HI 21
`define SFWP_BLK_LO 16
`define SFWP_SR_BP_LO 2
`define SFWP_SR_TB 6
`define SFWP_SR_STATUS_WRITE_GUARD 7
`endif

// ===== rtl/sfwp_pkg.sv
// Types of the serial flash write-protection block
`default_nettype none
package sfwp_pkg;
  typedef enum logic [1:0] {ST_STANDBY, ST_CMD, ST_ADDR, ST_DATA} sfwp_state_type;
  typedef struct packed {
    logic prog;
    logic erase;
    logic chip;
    logic otp;
    logic [23:0] addr;
  } sfwp_op_type;
endpackage
`default_nettype wire

// ===== rtl/sfwp_protect.sv
// Write-protection and secured OTP gate of a serial flash
`include "sfwp_consts.svh"
`default_nettype none
// How it works
// - Power-up reset puts the command machine in standby first.
// - Array or protection changes only after a complete command sequence.
// - Commands must end on a byte boundary or are dropped.
// - Data-changing commands need the write enable latch set.
// - Deep power-down ignores all but wake and signature commands.
// - Soft protect mode blocks program and erase in the protected region.
// - Low write-guard pin locks level, bottom and guard bits when guarded.
// - Bottom bit clear: levels 1 to 6 protect top 1 to 32 blocks.
// - Bottom bit set: levels 1 to 6 protect blocks upward from zero.
// - Levels 7 to 15 protect all 64 blocks.
// - Chip erase only when all level bits are zero.
// - A separate 4K-bit one-time area holds a serial number.
// - Security bit 0 shows the factory lock.
// - Between enter and exit OTP commands programming goes to OTP.
// - Write-security command sets customer lock bit 1.
// - Both locks are permanent once set.
// - Array access is denied while OTP mode is active.
// - OTP spans offsets 000 to 1FF, 4096 bits.
// - Single mode: line 0 in, line 1 out; dual and quad bidirectional; this block holds every output enable low, reads being outside it.
// - Write-guard pin is data line 2 in quad mode.
// - Pause pin suspends transfers, but is data line 3 in quad mode.
// - Pause is disabled in quad mode.
module sfwp_protect
  import sfwp_pkg::*;
#(
  parameter logic FACTORY_LOCKED = 1'b0
)(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic chip_select_n,
  input wire logic serial_clk,
  input wire logic data_line0,
  input wire logic write_guard_or_data2,
  input wire logic pause_or_data3,
  input wire logic quad_mode,
  input wire logic multi_mode,
  output logic data_line0_oe,
  output logic data_line1_oe,
  output logic data2_oe,
  output logic data3_oe,
  output logic write_enable_latch,
  output logic deep_power_down,
  output logic otp_mode,
  output logic [7:0] status_bits,
  output logic [1:0] security_bits,
  output logic op_valid,
  output var sfwp_op_type op_out
);
  // ****************************************
  // Pin synchronisers
  // ****************************************
  // Three stages; a change counts when stages two and three agree
  logic [2:0] cs_s_r, sck_s_r, d0_s_r, wp_s_r, hd_s_r;
  logic cs_q_r, sck_q_r, d0_q_r, wp_q_r, hd_q_r;
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      cs_s_r <= 3'h7;
      sck_s_r <= 3'h0;
      d0_s_r <= 3'h0;
      wp_s_r <= 3'h7;
      hd_s_r <= 3'h7;
    end
    else if (clk_en)
    begin
      cs_s_r <= {cs_s_r[1:0], chip_select_n};
      sck_s_r <= {sck_s_r[1:0], serial_clk};
      d0_s_r <= {d0_s_r[1:0], data_line0};
      wp_s_r <= {wp_s_r[1:0], write_guard_or_data2};
      hd_s_r <= {hd_s_r[1:0], pause_or_data3};
    end
  end
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      cs_q_r <= 1'b1;
      sck_q_r <= 1'b0;
      d0_q_r <= 1'b0;
      wp_q_r <= 1'b1;
      hd_q_r <= 1'b1;
    end
    else if (clk_en)
    begin
      if (cs_s_r[2] == cs_s_r[1]) cs_q_r <= cs_s_r[2];
      if (sck_s_r[2] == sck_s_r[1]) sck_q_r <= sck_s_r[2];
      if (d0_s_r[2] == d0_s_r[1]) d0_q_r <= d0_s_r[2];
      if (wp_s_r[2] == wp_s_r[1]) wp_q_r <= wp_s_r[2];
      if (hd_s_r[2] == hd_s_r[1]) hd_q_r <= hd_s_r[2];
    end
  end
  logic sck_d_r;
  always_ff @(posedge clk)
  begin
    if (sys_rst) sck_d_r <= 1'b0;
    else if (clk_en) sck_d_r <= sck_q_r;
  end
  // Pause only outside quad mode; data line 3 otherwise
  logic paused;
  assign paused = !quad_mode && !hd_q_r;
  logic sck_rise;
  assign sck_rise = sck_q_r && !sck_d_r && !cs_q_r && !paused;
  logic cs_rise;
  logic cs_d_r;
  always_ff @(posedge clk)
  begin
    if (sys_rst) cs_d_r <= 1'b1;
    else if (clk_en) cs_d_r <= cs_q_r;
  end
  assign cs_rise = cs_q_r && !cs_d_r;

  // ****************************************
  // Shifter and command capture
  // ****************************************
  sfwp_state_type state_r;
  logic [2:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic [7:0] cmd_r;
  logic [1:0] addr_cnt_r;
  logic [23:0] addr_r;
  logic [7:0] data_byte_r;
  logic got_data_r;
  logic [7:0] shift_nxt;
  assign shift_nxt = {shift_r[6:0], d0_q_r};
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_r <= ST_STANDBY;
      bit_cnt_r <= 3'h0;
      shift_r <= 8'h00;
      cmd_r <= 8'h00;
      addr_cnt_r <= 2'h0;
      addr_r <= 24'h000000;
      data_byte_r <= 8'h00;
      got_data_r <= 1'b0;
    end
    else if (clk_en)
    begin
      if (cs_q_r)
      begin
        state_r <= ST_STANDBY;
        bit_cnt_r <= 3'h0;
        addr_cnt_r <= 2'h0;
        got_data_r <= 1'b0;
      end
      else if (sck_rise)
      begin
        shift_r <= shift_nxt;
        bit_cnt_r <= bit_cnt_r + 3'h1;
        if (state_r == ST_STANDBY) state_r <= ST_CMD;
        if (bit_cnt_r == 3'h7)
        begin
          case (state_r)
            ST_STANDBY, ST_CMD:
            begin
              cmd_r <= shift_nxt;
              state_r <= ST_ADDR;
            end
            ST_ADDR:
            begin
              addr_r <= {addr_r[15:0], shift_nxt};
              addr_cnt_r <= addr_cnt_r + 2'h1;
              if (addr_cnt_r == 2'h2) state_r <= ST_DATA;
            end
            ST_DATA:
            begin
              data_byte_r <= shift_nxt;
              got_data_r <= 1'b1;
            end
            default: state_r <= ST_STANDBY;
          endcase
        end
      end
    end
  end

  // ****************************************
  // Command decode at deselect
  // ****************************************
  // Complete only when deselect lands on a byte boundary
  logic on_byte;
  logic seen_cmd;
  assign on_byte = (bit_cnt_r == 3'h0);
  assign seen_cmd = (state_r != ST_STANDBY) && (state_r != ST_CMD);
  logic done;
  assign done = cs_rise && on_byte && seen_cmd;
  logic addr_ok, one_byte;
  assign addr_ok = (state_r == ST_DATA) && (addr_cnt_r == 2'h3 || addr_cnt_r == 2'h0);
  assign one_byte = (state_r == ST_ADDR) && (addr_cnt_r == 2'h0);
  logic is_prog, is_erase, is_chip;
  assign is_prog = (cmd_r == `SFWP_CMD_PP || cmd_r == `SFWP_CMD_PP4) && addr_ok && got_data_r;
  assign is_erase = (cmd_r == `SFWP_CMD_SE || cmd_r == `SFWP_CMD_BE
    || cmd_r == `SFWP_CMD_BE32) && addr_ok && !got_data_r;
  assign is_chip = (cmd_r == `SFWP_CMD_CE1 || cmd_r == `SFWP_CMD_CE2) && one_byte;
  // Deep power-down admits only the wake/signature opcode
  logic allowed;
  assign allowed = !deep_power_down || cmd_r == `SFWP_CMD_WAKE
    || cmd_r == `SFWP_CMD_RSIG;
  logic act;
  assign act = done && allowed;

  // ****************************************
  // Protection decode
  // ****************************************
  logic [3:0] level;
  logic bottom;
  assign level = status_bits[`SFWP_SR_BP_LO+3:`SFWP_SR_BP_LO];
  assign bottom = status_bits[`SFWP_SR_TB];
  logic [5:0] blk;
  assign blk = addr_r[`SFWP_BLK_HI:`SFWP_BLK_LO];
  logic [5:0] span_mask;
  logic blk_prot;
  always_comb
  begin
    span_mask = 6'h3F << (level[2:0] - 3'h1);
    if (level == 4'h0) blk_prot = 1'b0;
    else if (level >= 4'h7) blk_prot = 1'b1;
    else if (bottom) blk_prot = (blk & span_mask) == 6'h00;
    else blk_prot = (~blk & span_mask) == 6'h00;
  end
  // Only offsets 000-1FF of the page-aligned window are the OTP area
  logic otp_addr_ok;
  assign otp_addr_ok = addr_r[11:0] <= `SFWP_OTP_LAST;
  logic otp_locked;
  assign otp_locked = security_bits[0] || security_bits[1];

  // ****************************************
  // Latches, status and OTP locks
  // ****************************************
  logic wr_ok;
  assign wr_ok = act && write_enable_latch;
  logic commit_prog, commit_erase, commit_chip;
  assign commit_prog = wr_ok && is_prog && (otp_mode ? (otp_addr_ok && !otp_locked)
    : !blk_prot);
  assign commit_erase = wr_ok && is_erase && !otp_mode && !blk_prot;
  assign commit_chip = wr_ok && is_chip && !otp_mode && level == 4'h0;
  logic wrsr_ok;
  assign wrsr_ok = wr_ok && cmd_r == `SFWP_CMD_WRSR && (state_r == ST_ADDR)
    && addr_cnt_r == 2'h1
    && !(status_bits[`SFWP_SR_STATUS_WRITE_GUARD] && !wp_q_r && !quad_mode);
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      write_enable_latch <= 1'b0;
      deep_power_down <= 1'b0;
      otp_mode <= 1'b0;
      status_bits <= 8'h00;
      security_bits <= 2'h0;
    end
    else if (clk_en)
    begin
      security_bits[0] <= security_bits[0] | FACTORY_LOCKED;
      if (act && one_byte)
      begin
        if (cmd_r == `SFWP_CMD_SET_WRITE_ENABLE_CMD) write_enable_latch <= 1'b1;
        if (cmd_r == `SFWP_CMD_WRDI) write_enable_latch <= 1'b0;
        if (cmd_r == `SFWP_CMD_DP) deep_power_down <= 1'b1;
        if (cmd_r == `SFWP_CMD_WAKE) deep_power_down <= 1'b0;
        if (cmd_r == `SFWP_CMD_ENTER_OTP_CMD) otp_mode <= 1'b1;
        if (cmd_r == `SFWP_CMD_EXIT_OTP_CMD) otp_mode <= 1'b0;
        if (wr_ok && cmd_r == `SFWP_CMD_WRITE_SECURITY_CMD)
        begin
          security_bits[1] <= 1'b1;
          write_enable_latch <= 1'b0;
        end
      end
      if (wrsr_ok)
      begin
        status_bits <= {addr_r[7:2], 2'h0};
        write_enable_latch <= 1'b0;
      end
      if (commit_prog || commit_erase || commit_chip) write_enable_latch <= 1'b0;
    end
  end

  // ****************************************
  // Operation issue and pin directions
  // ****************************************
  // Reads are outside this block, so data outputs stay released
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      op_valid <= 1'b0;
      op_out <= '0;
      data_line0_oe <= 1'b0;
      data_line1_oe <= 1'b0;
      data2_oe <= 1'b0;
      data3_oe <= 1'b0;
    end
    else if (clk_en)
    begin
      op_valid <= commit_prog || commit_erase || commit_chip;
      op_out <= '{prog: commit_prog, erase: commit_erase, chip: commit_chip,
        otp: otp_mode, addr: addr_r};
      data_line0_oe <= 1'b0;
      data_line1_oe <= 1'b0;
      data2_oe <= 1'b0;
      data3_oe <= 1'b0;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_wel_gate: assert property (@(posedge clk) disable iff (sys_rst)
    op_valid |-> $past(write_enable_latch)) else $error("Write op without latch");
  a_chip_level: assert property (@(posedge clk) disable iff (sys_rst)
    op_valid && op_out.chip |-> $past(level) == 4'h0) else $error("Chip erase while protected");
  a_dp_ignore: assert property (@(posedge clk) disable iff (sys_rst)
    $past(deep_power_down) && !$past(done && cmd_r == `SFWP_CMD_WAKE) |-> deep_power_down)
    else $error("Power-down left wrongly");
  a_lock_keep: assert property (@(posedge clk) disable iff (sys_rst)
    $past(security_bits[1]) |-> security_bits[1]) else $error("Customer lock cleared");
  a_byte_bound: assert property (@(posedge clk) disable iff (sys_rst)
    cs_rise && !on_byte |=> !op_valid) else $error("Partial byte executed");
  a_otp_array: assert property (@(posedge clk) disable iff (sys_rst)
    op_valid && op_out.otp |-> op_out.prog) else $error("Array touched in OTP mode");
  a_prot_all: assert property (@(posedge clk) disable iff (sys_rst)
    done && level >= 4'h7 && !otp_mode |=> !op_valid) else $error("Full protect broken");
  a_top_block: assert property (@(posedge clk) disable iff (sys_rst)
    level == 4'h1 && !bottom && blk == 6'h3F |-> blk_prot) else $error("Top block open");
  a_bot_block: assert property (@(posedge clk) disable iff (sys_rst)
    level == 4'h6 && bottom |-> blk_prot == (blk < 6'h20)) else $error("Bottom span wrong");
  c_prog: cover property (@(posedge clk) op_valid && op_out.prog);
  c_erase: cover property (@(posedge clk) op_valid && op_out.erase);
  c_otp: cover property (@(posedge clk) op_valid && op_out.otp);
  c_lock: cover property (@(posedge clk) security_bits[1]);
endmodule
`default_nettype wire

// ===== test/sfwp_host_model.sv
// Host serial controller model that drives the link pins
`include "sfwp_consts.svh"
`default_nettype none
module sfwp_host_model (
  input wire logic clk,
  output logic chip_select_n,
  output logic serial_clk,
  output logic data_line0
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************
  // Link frames
  // ****************
  localparam realtime HALF = 62.5;
  initial
  begin
    chip_select_n = 1'h1;
    serial_clk = 1'h0;
    data_line0 = 1'h0;
  end
  // Mode 0: clock stands low between frames; top n bits of d, MSB first
  // Start 1 ns past an edge so no pin change ever meets a clock edge
  task automatic send(input logic [39:0] d, input int n);
    @(posedge clk);
    #1;
    chip_select_n = 1'h0;
    for (int i = 0; i < n; i++)
    begin
      data_line0 = d[39 - i];
      #HALF;
      serial_clk = 1'h1;
      #HALF;
      serial_clk = 1'h0;
    end
    #HALF;
    chip_select_n = 1'h1;
    // Released line flips so a stale bit never passes for data
    data_line0 = ~data_line0;
    #(2 * HALF);
  endtask
  task automatic enable_write();
    send({`SFWP_CMD_SET_WRITE_ENABLE_CMD, 32'h0}, 8);
  endtask
endmodule
`default_nettype wire

// ===== test/testbench.sv
// Self-checking testbench of the serial flash write-protection block
`include "sfwp_consts.svh"
`default_nettype none
module testbench
  import sfwp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // ****************
  // Harness
  // ****************
  localparam logic FACT = 1'h0;
  logic clk = 1'h0;
  logic sys_rst = 1'h1;
  logic write_guard_or_data2 = 1'h1;
  logic pause_or_data3 = 1'h1;
  logic quad_mode = 1'h0;
  logic [3:0] oe;
  logic chip_select_n;
  logic serial_clk;
  logic data_line0;
  logic write_enable_latch;
  logic deep_power_down;
  logic otp_mode;
  logic op_valid;
  logic [7:0] status_bits;
  logic [1:0] security_bits;
  sfwp_op_type op_out;
  sfwp_op_type last_op;
  int num_errors = 0;
  int num_checks = 0;
  int pulses = 0;
  always #5 clk = ~clk;
  sfwp_host_model host (.clk(clk), .chip_select_n(chip_select_n), .serial_clk(serial_clk),
    .data_line0(data_line0));
  sfwp_protect #(.FACTORY_LOCKED(FACT)) i_sfwp_protect (.clk(clk), .sys_rst(sys_rst),
    .clk_en(1'h1), .chip_select_n(chip_select_n), .serial_clk(serial_clk),
    .data_line0(data_line0), .write_guard_or_data2(write_guard_or_data2),
    .pause_or_data3(pause_or_data3), .quad_mode(quad_mode), .multi_mode(1'h0),
    .data_line0_oe(oe[0]), .data_line1_oe(oe[1]), .data2_oe(oe[2]), .data3_oe(oe[3]),
    .write_enable_latch(write_enable_latch),
    .deep_power_down(deep_power_down), .otp_mode(otp_mode), .status_bits(status_bits),
    .security_bits(security_bits), .op_valid(op_valid), .op_out(op_out));
  // One-cycle pulse, so it is counted at every edge
  always @(posedge clk)
  begin
    if (op_valid === 1'h1)
    begin
      pulses <= pulses + 1;
      last_op <= op_out;
    end
  end
  task automatic check_bits(input logic [7:0] got, input logic [7:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic check_op(input sfwp_op_type exp, input string what);
    num_checks++;
    if (last_op !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, last_op, exp);
    end
  endtask
  task automatic cmd(input logic [39:0] d, input int n);
    host.send(d, n);
    repeat (12) @(posedge clk);
  endtask
  // Latch set first, then the frame; FF skips the pulse count
  task automatic op(input logic [39:0] d, input int n, input logic [7:0] exp, input string what);
    int p;
    p = pulses;
    host.enable_write();
    cmd(d, n);
    if (exp !== 8'hFF)
      check_bits(8'(pulses - p), exp, what);
  endtask
  task automatic set_level(input logic g, input logic b, input logic [3:0] lv);
    op({`SFWP_CMD_WRSR, g, b, lv, 2'h0, 24'h0}, 16, 8'hFF, "");
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic t_reset();
    check_bits({4'h0, write_enable_latch, deep_power_down, otp_mode, op_valid}, 8'h00, "idle");
    check_bits({6'h00, security_bits}, {7'h00, FACT}, "factory lock");
    check_bits({4'h0, oe}, 8'h00, "lines released");
  endtask
  task automatic t_latch();
    int p;
    p = pulses;
    cmd({`SFWP_CMD_PP, 24'h000100, 8'hA5}, 40);
    check_bits(8'(pulses - p), 8'h00, "program without latch");
    cmd({`SFWP_CMD_SET_WRITE_ENABLE_CMD, 32'h0}, 7);
    check_bits({7'h00, write_enable_latch}, 8'h00, "short enable");
    op({`SFWP_CMD_PP, 24'h000100, 8'hA5}, 39, 8'h00, "short program");
    op({`SFWP_CMD_PP4, 24'h000100, 8'hA5}, 40, 8'h01, "program");
    check_op('{1'h1, 1'h0, 1'h0, 1'h0, 24'h000100}, "program fields");
    check_bits({7'h00, write_enable_latch}, 8'h00, "latch after write");
  endtask
  task automatic t_levels();
    logic [3:0] lv[13] = '{4'h0, 4'h1, 4'h1, 4'h1, 4'h4, 4'h4, 4'h5, 4'h5, 4'h8, 4'h1, 4'h1,
      4'h6, 4'h6};
    logic bt[13] = '{1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h1,
      1'h1, 1'h1};
    logic [23:0] ad[13] = '{24'h3F0000, 24'h3F0000, 24'h7F0000, 24'h3E0000, 24'h380000,
      24'h370000, 24'h300000, 24'h2F0000, 24'h000000, 24'h000000, 24'h010000, 24'h1F0000,
      24'h200000};
    logic ok[13] = '{1'h1, 1'h0, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0, 1'h0, 1'h1,
      1'h0, 1'h1};
    logic [7:0] ec[3] = '{`SFWP_CMD_SE, `SFWP_CMD_BE, `SFWP_CMD_BE32};
    for (int i = 0; i < 13; i++)
    begin
      set_level(1'h0, bt[i], lv[i]);
      check_bits({4'h0, status_bits[`SFWP_SR_BP_LO +: 4]}, {4'h0, lv[i]}, "level");
      check_bits({7'h00, status_bits[`SFWP_SR_TB]}, {7'h00, bt[i]}, "bottom");
      op({ec[i % 3], ad[i], 8'h00}, 32, {7'h00, ok[i]}, "erase");
      op({(i % 2) ? `SFWP_CMD_CE2 : `SFWP_CMD_CE1, 32'h0}, 8, {7'h00, lv[i] == 4'h0}, "chip");
    end
  endtask
  task automatic t_guard();
    set_level(1'h1, 1'h0, 4'h0);
    check_bits({7'h00, status_bits[`SFWP_SR_STATUS_WRITE_GUARD]}, 8'h01, "guard set");
    @(posedge clk) write_guard_or_data2 <= 1'h0;
    set_level(1'h0, 1'h0, 4'h4);
    check_bits({4'h0, status_bits[`SFWP_SR_BP_LO +: 4]}, 8'h00, "guarded level");
    check_bits({7'h00, status_bits[`SFWP_SR_STATUS_WRITE_GUARD]}, 8'h01, "guarded bit");
    @(posedge clk) write_guard_or_data2 <= 1'h1;
    set_level(1'h0, 1'h0, 4'h0);
    check_bits({7'h00, status_bits[`SFWP_SR_STATUS_WRITE_GUARD]}, 8'h00, "guard clear");
  endtask
  task automatic t_pins();
    @(posedge clk) pause_or_data3 <= 1'h0;
    cmd({`SFWP_CMD_SET_WRITE_ENABLE_CMD, 32'h0}, 8);
    check_bits({7'h00, write_enable_latch}, 8'h00, "paused frame");
    @(posedge clk) quad_mode <= 1'h1;
    cmd({`SFWP_CMD_SET_WRITE_ENABLE_CMD, 32'h0}, 8);
    check_bits({7'h00, write_enable_latch}, 8'h01, "no pause in quad");
    cmd({`SFWP_CMD_WRDI, 32'h0}, 8);
    check_bits({7'h00, write_enable_latch}, 8'h00, "latch cleared");
    set_level(1'h1, 1'h0, 4'h0);
    @(posedge clk) write_guard_or_data2 <= 1'h0;
    set_level(1'h0, 1'h0, 4'h4);
    check_bits({4'h0, status_bits[`SFWP_SR_BP_LO +: 4]}, 8'h04, "guard pin as data");
    check_bits({4'h0, oe}, 8'h00, "quad lines released");
    @(posedge clk)
    begin
      write_guard_or_data2 <= 1'h1;
      quad_mode <= 1'h0;
      pause_or_data3 <= 1'h1;
    end
    set_level(1'h0, 1'h0, 4'h0);
    check_bits({4'h0, status_bits[`SFWP_SR_BP_LO +: 4]}, 8'h00, "level back");
  endtask
  task automatic t_power();
    cmd({`SFWP_CMD_DP, 32'h0}, 8);
    check_bits({7'h00, deep_power_down}, 8'h01, "power down");
    op({`SFWP_CMD_PP, 24'h0, 8'h11}, 40, 8'h00, "program asleep");
    check_bits({7'h00, write_enable_latch}, 8'h00, "latch asleep");
    cmd({`SFWP_CMD_WAKE, 32'h0}, 8);
    check_bits({7'h00, deep_power_down}, 8'h00, "wake");
  endtask
  task automatic t_otp();
    cmd({`SFWP_CMD_ENTER_OTP_CMD, 32'h0}, 8);
    check_bits({7'h00, otp_mode}, 8'h01, "otp on");
    op({`SFWP_CMD_PP, 12'h000, `SFWP_OTP_LAST, 8'h5A}, 40, 8'h01, "otp program");
    check_op('{1'h1, 1'h0, 1'h0, 1'h1, {12'h000, `SFWP_OTP_LAST}}, "otp fields");
    op({`SFWP_CMD_PP, 24'h000200, 8'h5A}, 40, 8'h00, "otp past end");
    op({`SFWP_CMD_SE, 24'h000000, 8'h00}, 32, 8'h00, "erase in otp");
    cmd({`SFWP_CMD_EXIT_OTP_CMD, 32'h0}, 8);
    check_bits({7'h00, otp_mode}, 8'h00, "otp off");
    for (int i = 0; i < 2; i++)
    begin
      op({`SFWP_CMD_WRITE_SECURITY_CMD, 32'h0}, 8, 8'hFF, "");
      check_bits({6'h00, security_bits}, {6'h00, 1'h1, FACT}, "customer lock");
    end
    cmd({`SFWP_CMD_ENTER_OTP_CMD, 32'h0}, 8);
    op({`SFWP_CMD_PP, 24'h000010, 8'h5A}, 40, 8'h00, "program locked");
    cmd({`SFWP_CMD_EXIT_OTP_CMD, 32'h0}, 8);
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    sys_rst <= 1'h0;
    repeat (4) @(posedge clk);
    t_reset();
    t_latch();
    t_levels();
    t_guard();
    t_pins();
    t_power();
    t_otp();
    complete_run();
  end
  // Hang guard well past the expected run length
  initial
  begin
    #800us;
    num_errors++;
    $display("CHECK FAILED at %0t: run did not finish", $time);
    complete_run();
  end
endmodule
`default_nettype wire
